// ==== hdl/sysbus_cfg.svh ====
// bus transfer attribute constants and functional notes
// Functional notes
// - The address bus has 32 lines and line 0 carries the most significant address bit.
// - The device drives the address when an internal master starts a transfer and takes it as input for an external master.
// - The two transfer size lines together give the operand bytes still to move; driven as master, sampled otherwise.
// - For a card interface access by an internal master the low size pin is an output selecting the card space.
// - The direction line is high for a read from the slave and low for a write to it.
// - The device drives the direction line while it owns the bus and takes it as input for an external master.
// - The burst line marks the transfer just started as a burst; driven as master, sampled from external masters.
// - During a burst the master holds burst-continue while more beats are wanted and drops it before the last beat.
// - When the second user machine controls a slave access, the burst-continue pin serves as that machine's line 5.
// - The master asserts the transfer-start strobe at the start of each data moving bus cycle.
// - The strobe is driven only after bus ownership is won and is deasserted before the bus is released.
// - When not master the device samples the strobe to detect an external synchronous master's cycle.
`ifndef SYSBUS_CFG_SVH
`define SYSBUS_CFG_SVH
`define ADDR_W 32
`define SIZE_W 2
`define BEAT_W 4
`define ADDR_ZERO 32'h0000_0000
`define SIZE_ZERO 2'h0
`define BEAT_ZERO 4'h0
`define BEAT_ONE 4'h1
`define BEAT_TWO 4'h2
`endif

// ==== hdl/sysbus_pkg.sv ====
// types shared by the bus transfer attribute logic
package sysbus_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_START = 4'h2,
        ST_DATA  = 4'h4,
        ST_END   = 4'h8
    } bus_state_t;
endpackage

// ==== hdl/pin_sync.sv ====
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// ==== hdl/sysbus_xfer.sv ====
// system bus address and transfer attribute pins, master and snoop sides
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
module sysbus_xfer
    import sysbus_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // internal master request side
    input wire logic bus_granted_i,
    input wire logic req_valid_i,
    input wire logic [`ADDR_W-1:0] req_addr_i,
    input wire logic [`SIZE_W-1:0] req_size_i,
    input wire logic req_read_i,
    input wire logic req_burst_i,
    input wire logic [`BEAT_W-1:0] req_beats_i,
    input wire logic req_card_i,
    input wire logic req_card_space_i,
    input wire logic machine_two_ctl_i,
    input wire logic machine_two_line_5_i,
    input wire logic beat_done_i,
    output logic req_ready_o,
    output logic busy_o,
    // pins
    input wire logic [0:`ADDR_W-1] addr_pin_i,
    output logic [0:`ADDR_W-1] addr_pin_o,
    output logic addr_pin_oe_o,
    input wire logic transfer_size_low_i,
    output logic transfer_size_low_o,
    output logic transfer_size_low_oe_o,
    input wire logic transfer_size_high_i,
    output logic transfer_size_high_o,
    output logic transfer_size_high_oe_o,
    input wire logic rd_wr_i,
    output logic rd_wr_o,
    output logic rd_wr_oe_o,
    input wire logic burst_i,
    output logic burst_o,
    output logic burst_oe_o,
    input wire logic burst_beat_continue_i,
    output logic burst_beat_continue_o,
    output logic burst_beat_continue_oe_o,
    input wire logic transfer_start_strobe_n_i,
    output logic transfer_start_strobe_n_o,
    output logic transfer_start_strobe_n_oe_o,
    // external master snoop results
    output logic ext_start_o,
    output logic [`ADDR_W-1:0] ext_addr_o,
    output logic [`SIZE_W-1:0] ext_size_o,
    output logic ext_read_o,
    output logic ext_burst_o,
    output logic ext_continue_o
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int SYNC_W = `ADDR_W + 6;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [`ADDR_W-1:0] addr_s;
    logic [`ADDR_W-1:0] addr_le;
    logic ts_s;
    logic ts_prev_q;
    logic ts_prev_d;

    // reverse pin order so bit 0 of the pin bus is the top address bit
    always_comb begin
        for (int i = 0; i < `ADDR_W; i++) begin
            addr_le[`ADDR_W-1-i] = addr_pin_i[i];
        end
    end

    // active-low pins enter inverted so the flops' reset level reads idle
    assign pins_raw = {addr_le, transfer_size_low_i, transfer_size_high_i,
                       rd_wr_i, !burst_i, !burst_beat_continue_i,
                       !transfer_start_strobe_n_i};

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(pins_raw),
        .sync_o(pins_s)
    );

    assign addr_s = pins_s[SYNC_W-1:6];
    assign ts_s = pins_s[0];

    // ************************************************************
    // master sequencer
    // ************************************************************
    bus_state_t state_q;
    bus_state_t state_d;
    logic [`BEAT_W-1:0] beats_q;
    logic [`BEAT_W-1:0] beats_d;
    logic [`ADDR_W-1:0] addr_q;
    logic [`ADDR_W-1:0] addr_d;
    logic [`SIZE_W-1:0] size_q;
    logic [`SIZE_W-1:0] size_d;
    logic read_q;
    logic read_d;
    logic burst_q;
    logic burst_d;
    logic card_q;
    logic card_d;
    logic space_q;
    logic space_d;
    logic own_q;
    logic own_d;
    logic ts_q;
    logic ts_d;
    logic cont_q;
    logic cont_d;
    logic ready_q;
    logic ready_d;

    // continue stays up while more than the final beat is outstanding
    function automatic logic more_beats(input logic [`BEAT_W-1:0] left);
        more_beats = (left >= `BEAT_TWO);
    endfunction

    always_comb begin
        state_d = state_q;
        beats_d = beats_q;
        addr_d = addr_q;
        size_d = size_q;
        read_d = read_q;
        burst_d = burst_q;
        card_d = card_q;
        space_d = space_q;
        own_d = own_q;
        ts_d = 1'b0;
        cont_d = cont_q;
        ready_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                own_d = 1'b0;
                // a request without the grant waits; no strobe off-grant
                if (req_valid_i && bus_granted_i) begin
                    state_d = ST_START;
                    own_d = 1'b1;
                    addr_d = req_addr_i;
                    size_d = req_size_i;
                    read_d = req_read_i;
                    burst_d = req_burst_i;
                    card_d = req_card_i;
                    space_d = req_card_space_i;
                    beats_d = req_burst_i ? req_beats_i : `BEAT_ONE;
                    ts_d = 1'b1;
                    cont_d = req_burst_i && more_beats(req_beats_i);
                    ready_d = 1'b1;
                end
            end
            ST_START: begin
                state_d = ST_DATA;
            end
            ST_DATA: begin
                if (beat_done_i) begin
                    beats_d = beats_q - `BEAT_ONE;
                    // drop continue before the expected last beat
                    cont_d = burst_q
                        && more_beats(beats_q - `BEAT_ONE);
                    if (beats_q == `BEAT_ONE) begin
                        state_d = ST_END;
                    end
                end
            end
            ST_END: begin
                // strobe already deasserted for a cycle or more before release
                own_d = 1'b0;
                cont_d = 1'b0;
                burst_d = 1'b0;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
                own_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            beats_q <= `BEAT_ZERO;
            addr_q <= `ADDR_ZERO;
            size_q <= `SIZE_ZERO;
            read_q <= 1'b0;
            burst_q <= 1'b0;
            card_q <= 1'b0;
            space_q <= 1'b0;
            own_q <= 1'b0;
            ts_q <= 1'b0;
            cont_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            beats_q <= beats_d;
            addr_q <= addr_d;
            size_q <= size_d;
            read_q <= read_d;
            burst_q <= burst_d;
            card_q <= card_d;
            space_q <= space_d;
            own_q <= own_d;
            ts_q <= ts_d;
            cont_q <= cont_d;
            ready_q <= ready_d;
        end
    end

    // ************************************************************
    // pin drive registers
    // ************************************************************
    logic [0:`ADDR_W-1] apin_q;
    logic [0:`ADDR_W-1] apin_d;
    logic tsl_q;
    logic tsl_d;
    logic tsh_q;
    logic tsh_d;
    logic burst_beat_continue_q;
    logic burst_beat_continue_d;
    logic burst_beat_continue_oe_q;
    logic burst_beat_continue_oe_d;

    // pins are registered so outputs come straight off flops
    always_comb begin
        for (int i = 0; i < `ADDR_W; i++) begin
            apin_d[i] = addr_d[`ADDR_W-1-i];
        end
        // card access reuses the low size pin as space select
        tsl_d = card_d ? space_d : size_d[1];
        tsh_d = size_d[0];
        // second user machine takes over the continue pin
        burst_beat_continue_d = machine_two_ctl_i ? machine_two_line_5_i
                                   : !cont_d;
        burst_beat_continue_oe_d = own_d || machine_two_ctl_i;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            apin_q <= `ADDR_ZERO;
            tsl_q <= 1'b0;
            tsh_q <= 1'b0;
            burst_beat_continue_q <= 1'b1;
            burst_beat_continue_oe_q <= 1'b0;
        end else begin
            apin_q <= apin_d;
            tsl_q <= tsl_d;
            tsh_q <= tsh_d;
            burst_beat_continue_q <= burst_beat_continue_d;
            burst_beat_continue_oe_q <= burst_beat_continue_oe_d;
        end
    end

    assign addr_pin_o = apin_q;
    assign addr_pin_oe_o = own_q;
    assign transfer_size_low_o = tsl_q;
    assign transfer_size_low_oe_o = own_q;
    assign transfer_size_high_o = tsh_q;
    assign transfer_size_high_oe_o = own_q;
    assign rd_wr_o = read_q;
    assign rd_wr_oe_o = own_q;
    assign burst_o = !burst_q;
    assign burst_oe_o = own_q;
    assign burst_beat_continue_o = burst_beat_continue_q;
    assign burst_beat_continue_oe_o = burst_beat_continue_oe_q;
    assign transfer_start_strobe_n_o = !ts_q;
    assign transfer_start_strobe_n_oe_o = own_q;
    assign req_ready_o = ready_q;
    assign busy_o = own_q;

    // ************************************************************
    // external master detection
    // ************************************************************
    logic ext_start_q;
    logic ext_start_d;
    logic [`ADDR_W-1:0] ext_addr_q;
    logic [`ADDR_W-1:0] ext_addr_d;
    logic [`SIZE_W-1:0] ext_size_q;
    logic [`SIZE_W-1:0] ext_size_d;
    logic ext_read_q;
    logic ext_read_d;
    logic ext_burst_q;
    logic ext_burst_d;
    logic ext_cont_q;
    logic ext_cont_d;
    logic ext_hit;

    // strobe assertion seen on the synced line while we are not master
    assign ext_hit = !own_q && !ts_prev_q && ts_s;

    always_comb begin
        ts_prev_d = ts_s;
        ext_start_d = ext_hit;
        ext_addr_d = ext_hit ? addr_s : ext_addr_q;
        ext_size_d = ext_hit ? {pins_s[5], pins_s[4]} : ext_size_q;
        ext_read_d = ext_hit ? pins_s[3] : ext_read_q;
        ext_burst_d = ext_hit ? pins_s[2] : ext_burst_q;
        // continue tracked live, already inverted to active high
        ext_cont_d = !own_q && pins_s[1];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ts_prev_q <= 1'b0;
            ext_start_q <= 1'b0;
            ext_addr_q <= `ADDR_ZERO;
            ext_size_q <= `SIZE_ZERO;
            ext_read_q <= 1'b0;
            ext_burst_q <= 1'b0;
            ext_cont_q <= 1'b0;
        end else begin
            ts_prev_q <= ts_prev_d;
            ext_start_q <= ext_start_d;
            ext_addr_q <= ext_addr_d;
            ext_size_q <= ext_size_d;
            ext_read_q <= ext_read_d;
            ext_burst_q <= ext_burst_d;
            ext_cont_q <= ext_cont_d;
        end
    end

    assign ext_start_o = ext_start_q;
    assign ext_addr_o = ext_addr_q;
    assign ext_size_o = ext_size_q;
    assign ext_read_o = ext_read_q;
    assign ext_burst_o = ext_burst_q;
    assign ext_continue_o = ext_cont_q;
endmodule

// ==== sim/sysbus_xfer_monitor.sv ====
// assertion checker for the bus transfer attribute pins
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
module sysbus_xfer_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] req_addr_i,
    input wire logic [`SIZE_W-1:0] req_size_i,
    input wire logic req_read_i,
    input wire logic req_burst_i,
    input wire logic [`BEAT_W-1:0] req_beats_i,
    input wire logic req_card_i,
    input wire logic req_card_space_i,
    input wire logic machine_two_ctl_i,
    input wire logic machine_two_line_5_i,
    input wire logic req_ready_o,
    input wire logic busy_o,
    input wire logic [0:`ADDR_W-1] addr_pin_o,
    input wire logic addr_pin_oe_o,
    input wire logic transfer_size_low_o,
    input wire logic transfer_size_high_o,
    input wire logic rd_wr_o,
    input wire logic rd_wr_oe_o,
    input wire logic burst_o,
    input wire logic burst_oe_o,
    input wire logic burst_beat_continue_o,
    input wire logic transfer_start_strobe_n_i,
    input wire logic transfer_start_strobe_n_o,
    input wire logic transfer_start_strobe_n_oe_o,
    input wire logic ext_start_o
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_oe_group;
        addr_pin_oe_o == rd_wr_oe_o && rd_wr_oe_o == burst_oe_o
            && burst_oe_o == transfer_start_strobe_n_oe_o;
    endproperty
    a_oe_group: assert property (p_oe_group)
        else $error("pin enables disagree");
    property p_answer;
        $rose(req_ready_o) |-> !transfer_start_strobe_n_o && addr_pin_oe_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("taken request not driven");
    property p_addr;
        req_ready_o |-> addr_pin_o == req_addr_i;
    endproperty
    a_addr: assert property (p_addr)
        else $error("address pins wrong");
    property p_attr;
        req_ready_o |-> rd_wr_o == req_read_i && burst_o == !req_burst_i
            && transfer_size_high_o == req_size_i[0];
    endproperty
    a_attr: assert property (p_attr)
        else $error("attribute pins wrong");
    property p_size_low;
        req_ready_o |-> transfer_size_low_o ==
            (req_card_i ? req_card_space_i : req_size_i[1]);
    endproperty
    a_size_low: assert property (p_size_low)
        else $error("low size pin wrong");
    property p_cont;
        req_ready_o && !machine_two_ctl_i |-> burst_beat_continue_o ==
            !(req_burst_i && req_beats_i >= 4'h2);
    endproperty
    a_cont: assert property (p_cont)
        else $error("continue pin wrong at start");
    property p_ts_one;
        !transfer_start_strobe_n_o |=> transfer_start_strobe_n_o;
    endproperty
    a_ts_one: assert property (p_ts_one)
        else $error("strobe longer than one cycle");
    property p_ts_own;
        !transfer_start_strobe_n_o |-> transfer_start_strobe_n_oe_o;
    endproperty
    a_ts_own: assert property (p_ts_own)
        else $error("strobe without ownership");
    property p_release;
        $fell(transfer_start_strobe_n_oe_o) |->
            $past(transfer_start_strobe_n_o);
    endproperty
    a_release: assert property (p_release)
        else $error("bus released with strobe low");
    property p_hold;
        addr_pin_oe_o && $past(addr_pin_oe_o) |-> $stable(addr_pin_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("address moved mid cycle");
    property p_machine;
        machine_two_ctl_i && $past(machine_two_ctl_i) |->
            burst_beat_continue_o == $past(machine_two_line_5_i);
    endproperty
    a_machine: assert property (p_machine)
        else $error("line 5 not on continue pin");
    // sync flops delay detection, so allow a short window
    property p_snoop;
        $fell(transfer_start_strobe_n_i) && !busy_o && !addr_pin_oe_o
            |-> ##[2:5] ext_start_o;
    endproperty
    a_snoop: assert property (p_snoop)
        else $error("external cycle missed");
    c_burst: cover property (req_ready_o && req_burst_i);
    c_ext: cover property (ext_start_o);
    c_m2: cover property (machine_two_ctl_i && !burst_beat_continue_o);
endmodule
bind sysbus_xfer sysbus_xfer_monitor mon (.*);

// ==== sim/ext_master_model.sv ====
// far side: an external synchronous master that borrows the bus
`timescale 1ns/1ns
module ext_master_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [3:0] hold_i,
    input wire logic dev_oe_i,
    output logic oe_o,
    output logic ts_n_o
);
    logic [3:0] cnt_q;
    // ****************
    // ownership sequence
    // ****************
    // take the bus only while the device leaves it, hold_i sets the pace
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_o <= 1'b0;
            ts_n_o <= 1'b1;
            cnt_q <= 4'h0;
        end else if (!oe_o && go_i && !dev_oe_i) begin
            oe_o <= 1'b1;
            ts_n_o <= 1'b0;
            cnt_q <= hold_i;
        end else if (oe_o) begin
            ts_n_o <= 1'b1;
            if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (ts_n_o) begin
                oe_o <= 1'b0;
            end
        end
    end
endmodule

// ==== sim/sysbus_xfer_tb.sv ====
// self-checking bench for the bus transfer attribute pins
`timescale 1ns/1ns
module sysbus_xfer_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus_granted_i, req_valid_i, req_read_i, req_burst_i;
    logic req_card_i, req_card_space_i, beat_done_i;
    logic machine_two_ctl_i, machine_two_line_5_i;
    logic [31:0] req_addr_i, m_addr, ext_addr_o;
    logic [1:0] req_size_i, m_size, ext_size_o;
    logic [3:0] req_beats_i, m_hold;
    logic req_ready_o, busy_o, addr_pin_oe_o, ext_start_o;
    logic [0:31] addr_pin_i, addr_pin_o;
    logic transfer_size_low_i, transfer_size_low_o, transfer_size_low_oe_o;
    logic transfer_size_high_i, transfer_size_high_o;
    logic transfer_size_high_oe_o, rd_wr_i, rd_wr_o, rd_wr_oe_o;
    logic burst_i, burst_o, burst_oe_o, burst_beat_continue_i;
    logic burst_beat_continue_o, burst_beat_continue_oe_o;
    logic transfer_start_strobe_n_i, transfer_start_strobe_n_o;
    logic transfer_start_strobe_n_oe_o;
    logic ext_read_o, ext_burst_o, ext_continue_o;
    logic m_go, m_rd, m_burst, m_oe, m_ts_n;
    logic fl_q = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    // ****************
    // clock, wires, instances
    // ****************
    always #10 ref_clk_i = ~ref_clk_i;
    // released lines flip each cycle so a stale value never looks valid
    always @(posedge ref_clk_i) fl_q <= ~fl_q;
    assign addr_pin_i = addr_pin_oe_o ? addr_pin_o
        : m_oe ? m_addr : {32{fl_q}};
    assign transfer_size_low_i = transfer_size_low_oe_o
        ? transfer_size_low_o : m_oe ? m_size[1] : fl_q;
    assign transfer_size_high_i = transfer_size_high_oe_o
        ? transfer_size_high_o : m_oe ? m_size[0] : fl_q;
    assign rd_wr_i = rd_wr_oe_o ? rd_wr_o : m_oe ? m_rd : fl_q;
    assign burst_i = burst_oe_o ? burst_o : m_oe ? m_burst : fl_q;
    assign burst_beat_continue_i = burst_beat_continue_oe_o
        ? burst_beat_continue_o : m_oe ? m_burst : fl_q;
    // strobe line has a pull-up when nobody drives it
    assign transfer_start_strobe_n_i = transfer_start_strobe_n_oe_o
        ? transfer_start_strobe_n_o : m_oe ? m_ts_n : 1'b1;
    sysbus_xfer uut (.*);
    ext_master_model model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .go_i(m_go), .hold_i(m_hold), .dev_oe_i(addr_pin_oe_o),
        .oe_o(m_oe), .ts_n_o(m_ts_n));
    // ****************
    // helpers and scenarios
    // ****************
    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wait_for(ref logic f, input logic v);
        int i;
        i = 0;
        while (f !== v && i < 20) begin
            tick(1);
            i++;
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_master(input logic [31:0] a, input logic [1:0] sz,
        input logic rd, bu, input logic [3:0] nb, input logic cd, sp);
        int n;
        n = bu ? nb : 1;
        {req_addr_i, req_size_i, req_read_i, req_burst_i} = {a, sz, rd, bu};
        {req_beats_i, req_card_i, req_card_space_i} = {nb, cd, sp};
        req_valid_i = 1'b1;
        wait_for(req_ready_o, 1'b1);
        chk("ready", req_ready_o, 1'b1);
        chk("addr", addr_pin_o, a);
        chk("addr msb", addr_pin_o[0], a[31]);
        chk("addr oe", addr_pin_oe_o, 1'b1);
        chk("rw oe", rd_wr_oe_o, 1'b1);
        chk("busy", busy_o, 1'b1);
        chk("size oe", {transfer_size_low_oe_o, transfer_size_high_oe_o},
            2'h3);
        chk("cont oe", burst_beat_continue_oe_o, 1'b1);
        chk("size high", transfer_size_high_o, sz[0]);
        chk("size low", transfer_size_low_o, cd ? sp : sz[1]);
        chk("rw", rd_wr_o, rd);
        chk("burst", burst_o, !bu);
        chk("strobe", transfer_start_strobe_n_o, 1'b0);
        chk("cont", burst_beat_continue_o, !(n >= 2));
        req_valid_i = 1'b0;
        tick(1);
        chk("strobe end", transfer_start_strobe_n_o, 1'b1);
        for (int k = 1; k <= n; k++) begin
            beat_done_i = 1'b1;
            tick(1);
            beat_done_i = 1'b0;
            tick(1);
            chk("cont beat", burst_beat_continue_o, !(n - k >= 2));
        end
        wait_for(addr_pin_oe_o, 1'b0);
        chk("released", addr_pin_oe_o, 1'b0);
        chk("ts oe", transfer_start_strobe_n_oe_o, 1'b0);
        chk("not busy", busy_o, 1'b0);
        chk("cont off", burst_beat_continue_oe_o, 1'b0);
        tick(2);
    endtask
    task automatic t_refused();
        bus_granted_i = 1'b0;
        req_valid_i = 1'b1;
        repeat (6) begin
            tick(1);
            chk("no grant", req_ready_o | addr_pin_oe_o, 1'b0);
        end
        req_valid_i = 1'b0;
        bus_granted_i = 1'b1;
        tick(2);
    endtask
    task automatic t_machine2();
        machine_two_ctl_i = 1'b1;
        for (int v = 0; v < 2; v++) begin
            machine_two_line_5_i = v[0];
            tick(2);
            chk("line 5", burst_beat_continue_o, v[0]);
            chk("line 5 oe", burst_beat_continue_oe_o, 1'b1);
        end
        machine_two_ctl_i = 1'b0;
        tick(2);
    endtask
    task automatic t_reset_mid();
        req_valid_i = 1'b1;
        tick(3);
        req_valid_i = 1'b0;
        rst_i = 1'b1;
        tick(1);
        chk("reset oe", addr_pin_oe_o | burst_oe_o, 1'b0);
        chk("reset ts", transfer_start_strobe_n_o, 1'b1);
        rst_i = 1'b0;
        tick(1);
        chk("no false start", ext_start_o, 1'b0);
        chk("no false cont", ext_continue_o, 1'b0);
        tick(1);
    endtask
    task automatic t_ext(input logic [31:0] a, input logic [1:0] sz,
        input logic rd, bu, input logic [3:0] h);
        bus_granted_i = 1'b0;
        {m_addr, m_size, m_rd, m_burst, m_hold} = {a, sz, rd, !bu, h};
        m_go = 1'b1;
        tick(1);
        m_go = 1'b0;
        wait_for(ext_start_o, 1'b1);
        chk("ext start", ext_start_o, 1'b1);
        chk("ext addr", ext_addr_o, a);
        chk("ext size", ext_size_o, sz);
        chk("ext rw", ext_read_o, rd);
        chk("ext burst", ext_burst_o, bu);
        chk("float", addr_pin_oe_o | rd_wr_oe_o, 1'b0);
        chk("ext cont", ext_continue_o, bu);
        chk("cont float", burst_beat_continue_oe_o | busy_o, 1'b0);
        tick(h + 4);
        bus_granted_i = 1'b1;
    endtask
    // ****************
    // main sequence and watchdog
    // ****************
    initial begin
        {bus_granted_i, req_valid_i, req_read_i, req_burst_i} = 4'h0;
        {req_card_i, req_card_space_i, beat_done_i, m_go} = 4'h0;
        {machine_two_ctl_i, machine_two_line_5_i, m_rd, m_burst} = 4'h0;
        {req_addr_i, m_addr, req_size_i, m_size} = '0;
        {req_beats_i, m_hold} = 8'h00;
        tick(5);
        chk("rst oe", addr_pin_oe_o | transfer_start_strobe_n_oe_o,
            1'b0);
        rst_i = 1'b0;
        bus_granted_i = 1'b1;
        tick(1);
        chk("rst start", ext_start_o, 1'b0);
        chk("rst cont", ext_continue_o, 1'b0);
        for (int s = 0; s < 4; s++) begin
            t_master(32'h8000_0001 >> s, s[1:0], s[0], 1'b0, 4'h0, 1'b0, 1'b0);
        end
        t_master(32'hFFFF_FFFC, 2'h0, 1'b1, 1'b1, 4'h4, 1'b0, 1'b0);
        t_master(32'h0000_0010, 2'h0, 1'b0, 1'b1, 4'h2, 1'b0, 1'b0);
        t_master(32'h0000_0100, 2'h0, 1'b1, 1'b0, 4'h0, 1'b1, 1'b1);
        t_master(32'h0000_0200, 2'h2, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
        t_refused();
        t_machine2();
        t_reset_mid();
        t_ext(32'h89AB_CDEF, 2'h1, 1'b1, 1'b0, 4'h5);
        t_ext(32'h0123_4567, 2'h2, 1'b0, 1'b1, 4'h9);
        conclude();
    end
    // run needs well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule
